// ==== hw/signal_monitor_fast_detect_regs.sv ====
/*
 * Level monitor and threshold-detect register bank behind the three-wire
 * configuration port, with the peak tracker and sideband feed.
 * Assumes port clock at most one eighth of clk; sample path on clk.
 */
// Behaviour
// [RULE_01] The 20-bit result reads over three bytes with the peak in bits 19:7 and zeros below.
// [RULE_02] Result selection resets to one for the peak source; zero is reserved for software.
// [RULE_03] The peak tracker runs only while monitor control bit 1 is set, off after reset.
// [RULE_04] Peak results reach the sideband path only when source select bit 1 and its enable are set; only valid is gated, peak updates every period.
// [RULE_05] Dwell is 16 bits and thresholds 13 bits, each split low/high, all zero at reset.
// [RULE_06] Writing one to the update bit latches result and period count, then the bit clears itself.
// [RULE_07] With the force bit set the detect pin carries the force value, not the comparison.
`timescale 1ns/10ps
`default_nettype none

module signal_monitor_fast_detect_regs (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// configuration port pins
	input wire logic spi_sclk,
	input wire logic spi_csb_n,
	input wire logic spi_sdio_in,
	output logic spi_sdio_out,
	output logic spi_sdio_oe,
	// sample path
	input wire logic sample_valid,
	input wire logic signed [13:0] sample,
	input wire logic sync_pulse,
	input wire logic detect_compare,
	// outputs
	output logic level_threshold_detect_pin,
	output mon_pkg::detect_cfg_t detect_cfg,
	output logic [1:0] sync_mode,
	output mon_pkg::sideband_t sideband_serial_port
);

	typedef struct packed {
		logic sclk_meta, sclk_s, sclk_prev;
		logic csb_meta, csb_s;
		logic sdi_meta, sdi_s;
		logic [4:0] bit_cnt;
		logic [15:0] shift_in;
		logic rw;
		logic [14:0] addr;
		logic data_phase;
		logic [7:0] out_sh;
		logic sdo_oe;
		logic [7:0] det_ctl;
		logic [12:0] upper;
		logic [12:0] lower;
		logic [15:0] dwell;
		logic [1:0] sync_mode;
		logic peak_en;
		logic [23:0] period;
		logic result_sel;
		logic update;
		logic [19:0] result;
		logic [7:0] count_res;
		logic link_en;
		logic link_peak;
		logic det_pin;
		mon_pkg::sideband_t side;
	} state_t;

	state_t q;
	state_t d;
	logic pk_done;
	logic [12:0] pk_last;
	logic [7:0] pk_count;
	logic [15:0] word;
	logic restart;

	// -------------------------------------------------------------------
	// read decode
	// -------------------------------------------------------------------
	function automatic logic [7:0] read_byte(input state_t s, input logic [14:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a == mon_pkg::addr_detect_control) begin
			r = s.det_ctl;
		end else if (a == mon_pkg::addr_upper_threshold_low) begin
			r = s.upper[7:0];
		end else if (a == mon_pkg::addr_upper_threshold_high) begin
			r = {3'h0, s.upper[12:8]};
		end else if (a == mon_pkg::addr_lower_threshold_low) begin
			r = s.lower[7:0];
		end else if (a == mon_pkg::addr_lower_threshold_high) begin
			r = {3'h0, s.lower[12:8]};
		end else if (a == mon_pkg::addr_dwell_time_low) begin
			r = s.dwell[7:0];
		end else if (a == mon_pkg::addr_dwell_time_high) begin
			r = s.dwell[15:8];
		end else if (a == mon_pkg::addr_monitor_sync_control) begin
			r = {6'h00, s.sync_mode};
		end else if (a == mon_pkg::addr_monitor_control) begin
			r = {6'h00, s.peak_en, 1'b0};
		end else if (a == mon_pkg::addr_monitor_period_0) begin
			r = s.period[7:0];
		end else if (a == mon_pkg::addr_monitor_period_1) begin
			r = s.period[15:8];
		end else if (a == mon_pkg::addr_monitor_period_2) begin
			r = s.period[23:16];
		end else if (a == mon_pkg::addr_monitor_result_control) begin
			r = {3'h0, s.update, 3'h0, s.result_sel};
		end else if (a == mon_pkg::addr_monitor_result_0) begin
			r = s.result[7:0];
		end else if (a == mon_pkg::addr_monitor_result_1) begin
			r = s.result[15:8];
		end else if (a == mon_pkg::addr_monitor_result_2) begin
			r = {4'h0, s.result[19:16]};
		end else if (a == mon_pkg::addr_period_count_result) begin
			r = s.count_res;
		end else if (a == mon_pkg::addr_link_sideband_control) begin
			r = {7'h00, s.link_en};
		end else if (a == mon_pkg::addr_link_sideband_source_select) begin
			r = {6'h00, s.link_peak, 1'b0};
		end
		return r;
	endfunction : read_byte

	// -------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------
	always_comb begin
		d = q;
		word = {q.shift_in[14:0], q.sdi_s};
		restart = sync_pulse && (q.sync_mode != mon_pkg::sync_disabled);
		// pins pass two flops before any logic looks at them
		d.sclk_meta = spi_sclk;
		d.sclk_s = q.sclk_meta;
		d.sclk_prev = q.sclk_s;
		d.csb_meta = spi_csb_n;
		d.csb_s = q.csb_meta;
		d.sdi_meta = spi_sdio_in;
		d.sdi_s = q.sdi_meta;
		// [RULE_06] update bit clears
		d.update = 1'b0;
		if (q.csb_s) begin
			d.bit_cnt = 5'h00;
			d.data_phase = 1'b0;
			d.sdo_oe = 1'b0;
		end else if (q.sclk_s && !q.sclk_prev) begin
			d.shift_in = word;
			d.bit_cnt = 5'(q.bit_cnt + 5'h01);
			if (!q.data_phase && q.bit_cnt == mon_pkg::instr_last_bit) begin
				d.rw = word[15];
				d.addr = word[14:0];
				d.data_phase = 1'b1;
				d.bit_cnt = 5'h00;
			end else if (q.data_phase && q.bit_cnt == mon_pkg::data_last_bit) begin
				d.bit_cnt = 5'h00;
				d.addr = 15'(q.addr + 15'h0001);
				if (!q.rw) begin
					if (q.addr == mon_pkg::addr_detect_control) begin
						d.det_ctl = word[7:0];
					// [RULE_05] split threshold and dwell
					end else if (q.addr == mon_pkg::addr_upper_threshold_low) begin
						d.upper[7:0] = word[7:0];
					end else if (q.addr == mon_pkg::addr_upper_threshold_high) begin
						d.upper[12:8] = word[4:0];
					end else if (q.addr == mon_pkg::addr_lower_threshold_low) begin
						d.lower[7:0] = word[7:0];
					end else if (q.addr == mon_pkg::addr_lower_threshold_high) begin
						d.lower[12:8] = word[4:0];
					end else if (q.addr == mon_pkg::addr_dwell_time_low) begin
						d.dwell[7:0] = word[7:0];
					end else if (q.addr == mon_pkg::addr_dwell_time_high) begin
						d.dwell[15:8] = word[7:0];
					end else if (q.addr == mon_pkg::addr_monitor_sync_control) begin
						d.sync_mode = word[1:0];
					end else if (q.addr == mon_pkg::addr_monitor_control) begin
						d.peak_en = word[mon_pkg::peak_enable_bit];
					end else if (q.addr == mon_pkg::addr_monitor_period_0) begin
						d.period[7:0] = word[7:0];
					end else if (q.addr == mon_pkg::addr_monitor_period_1) begin
						d.period[15:8] = word[7:0];
					end else if (q.addr == mon_pkg::addr_monitor_period_2) begin
						d.period[23:16] = word[7:0];
					end else if (q.addr == mon_pkg::addr_monitor_result_control) begin
						// [RULE_02] zero is stored but selects nothing
						d.result_sel = word[mon_pkg::result_select_bit];
						d.update = word[mon_pkg::result_update_bit];
					end else if (q.addr == mon_pkg::addr_link_sideband_control) begin
						d.link_en = word[mon_pkg::link_enable_bit];
					end else if (q.addr == mon_pkg::addr_link_sideband_source_select) begin
						d.link_peak = word[mon_pkg::link_peak_source_bit];
					end
				end
			end
		end else if (!q.sclk_s && q.sclk_prev && q.data_phase && q.rw) begin
			// first fall of each byte loads, later falls shift
			d.out_sh = (q.bit_cnt == 5'h00) ? read_byte(q, q.addr) : {q.out_sh[6:0], 1'b0};
			d.sdo_oe = 1'b1;
		end
		// one-shot sync disarms itself after use
		if (restart && q.sync_mode == mon_pkg::sync_one_shot) begin
			d.sync_mode = mon_pkg::sync_disabled;
		end
		// [RULE_06] latch on update
		if (q.update) begin
			// [RULE_01] peak in upper bits
			d.result = q.result_sel ? {pk_last, 7'h00} : 20'h00000;
			d.count_res = pk_count;
		end
		// [RULE_07] force overrides compare
		if (q.det_ctl[mon_pkg::detect_force_bit]) begin
			d.det_pin = q.det_ctl[mon_pkg::detect_force_value_bit];
		end else begin
			d.det_pin = q.det_ctl[mon_pkg::detect_enable_bit] && detect_compare;
		end
		// [RULE_04] sideband gated
		d.side.valid = pk_done && q.link_en && q.link_peak;
		d.side.peak = pk_done ? pk_last : q.side.peak;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
			q.sclk_meta <= 1'b0;
			q.csb_meta <= 1'b1;
			q.csb_s <= 1'b1;
			q.det_ctl <= mon_pkg::rst_detect_control;
			q.upper <= mon_pkg::rst_threshold;
			q.lower <= mon_pkg::rst_threshold;
			q.dwell <= mon_pkg::rst_dwell;
			q.period <= mon_pkg::rst_period;
			q.result_sel <= mon_pkg::rst_result_select;
		end else begin
			q <= d;
		end
	end

	// [RULE_03] tracker gated by enable
	peak_track u_peak (
		.clk(clk),
		.sys_rst(sys_rst),
		.enable(q.peak_en),
		.restart(restart),
		.period(q.period),
		.sample_valid(sample_valid),
		.sample(sample),
		.done(pk_done),
		.peak(pk_last),
		.count(pk_count)
	);

	assign spi_sdio_out = q.out_sh[7];
	assign spi_sdio_oe = q.sdo_oe;
	assign level_threshold_detect_pin = q.det_pin;
	assign detect_cfg = '{upper: q.upper, lower: q.lower, dwell: q.dwell,
		enable: q.det_ctl[mon_pkg::detect_enable_bit]};
	assign sync_mode = q.sync_mode;
	assign sideband_serial_port = q.side;

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	result_layout_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
		q.update && q.result_sel |=> q.result == {$past(pk_last), 7'h00})
		else $error("result not latched as peak over zeros");
	select_default_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
		$past(sys_rst) |-> q.result_sel && read_byte(q, mon_pkg::addr_monitor_result_control) == 8'h01)
		else $error("result control not one after reset");
	peak_gate_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
		!q.peak_en |=> !pk_done)
		else $error("peak tracker ran while disabled");
	sideband_gate_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
		q.side.valid |-> $past(pk_done) && $past(q.link_en) && $past(q.link_peak))
		else $error("sideband fed without both enables");
	config_reset_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
		$past(sys_rst) |-> q.upper == 13'h0000 && q.lower == 13'h0000 && q.dwell == 16'h0000)
		else $error("threshold or dwell not zero after reset");
	update_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
		q.update ##1 !(q.csb_s == 1'b0 && q.data_phase) |-> !q.update)
		else $error("update bit did not clear itself");
	detect_force_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
		q.det_ctl[mon_pkg::detect_force_bit] |=>
		level_threshold_detect_pin == $past(q.det_ctl[mon_pkg::detect_force_value_bit]))
		else $error("detect pin ignored force value");

endmodule : signal_monitor_fast_detect_regs

`default_nettype wire

// ==== hw/mon_pkg.sv ====
/*
 * Shared constants and types for the level monitor register bank: register
 * offsets, reset values, serial port framing and the packed carriers.
 * Assumes a single converter clock and a three-wire configuration port.
 */
package mon_pkg;

	// ---------------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------------
	localparam logic [14:0] addr_detect_control = 15'h0245;
	localparam logic [14:0] addr_upper_threshold_low = 15'h0247;
	localparam logic [14:0] addr_upper_threshold_high = 15'h0248;
	localparam logic [14:0] addr_lower_threshold_low = 15'h0249;
	localparam logic [14:0] addr_lower_threshold_high = 15'h024a;
	localparam logic [14:0] addr_dwell_time_low = 15'h024b;
	localparam logic [14:0] addr_dwell_time_high = 15'h024c;
	localparam logic [14:0] addr_monitor_sync_control = 15'h026f;
	localparam logic [14:0] addr_monitor_control = 15'h0270;
	localparam logic [14:0] addr_monitor_period_0 = 15'h0271;
	localparam logic [14:0] addr_monitor_period_1 = 15'h0272;
	localparam logic [14:0] addr_monitor_period_2 = 15'h0273;
	localparam logic [14:0] addr_monitor_result_control = 15'h0274;
	localparam logic [14:0] addr_monitor_result_0 = 15'h0275;
	localparam logic [14:0] addr_monitor_result_1 = 15'h0276;
	localparam logic [14:0] addr_monitor_result_2 = 15'h0277;
	localparam logic [14:0] addr_period_count_result = 15'h0278;
	localparam logic [14:0] addr_link_sideband_control = 15'h0279;
	localparam logic [14:0] addr_link_sideband_source_select = 15'h027a;

	// ---------------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------------
	localparam int detect_enable_bit = 0;
	localparam int detect_force_value_bit = 2;
	localparam int detect_force_bit = 3;
	localparam int peak_enable_bit = 1;
	localparam int result_select_bit = 0;
	localparam int result_update_bit = 4;
	localparam int link_enable_bit = 0;
	localparam int link_peak_source_bit = 1;
	localparam int result_peak_lsb = 7;
	localparam logic [7:0] rst_detect_control = 8'h00;
	localparam logic [12:0] rst_threshold = 13'h0000;
	localparam logic [15:0] rst_dwell = 16'h0000;
	localparam logic [23:0] rst_period = 24'h000080;
	localparam logic rst_result_select = 1'h1;
	localparam logic [1:0] sync_disabled = 2'h0;
	localparam logic [1:0] sync_one_shot = 2'h2;

	// ---------------------------------------------------------------------
	// serial port framing
	// ---------------------------------------------------------------------
	localparam logic [4:0] instr_last_bit = 5'h0f;
	localparam logic [4:0] data_last_bit = 5'h07;

	// ---------------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------------
	typedef struct packed {
		logic [12:0] upper;
		logic [12:0] lower;
		logic [15:0] dwell;
		logic enable;
	} detect_cfg_t;

	typedef struct packed {
		logic valid;
		logic [12:0] peak;
	} sideband_t;

endpackage : mon_pkg

// ==== hw/peak_track.sv ====
/*
 * Peak magnitude tracker: holds the largest absolute sample seen over one
 * monitor period and counts finished periods.
 * Assumes samples arrive one per decimated output clock on sample_valid.
 */
`timescale 1ns/10ps
`default_nettype none

module peak_track (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire logic enable,
	input wire logic restart,
	input wire logic [23:0] period,
	// samples
	input wire logic sample_valid,
	input wire logic signed [13:0] sample,
	// results
	output logic done,
	output logic [12:0] peak,
	output logic [7:0] count
);

	typedef struct packed {
		logic [23:0] cnt;
		logic [12:0] cur;
		logic [12:0] last;
		logic [7:0] periods;
		logic done;
	} track_t;

	track_t q;
	track_t d;
	logic [13:0] mag;
	logic [12:0] sat;
	logic [12:0] hi;

	always_comb begin
		mag = sample[13] ? 14'(-sample) : 14'(sample);
		// most negative code has no positive twin in 13 bits
		sat = mag[13] ? 13'h1fff : mag[12:0];
		hi = (sat > q.cur) ? sat : q.cur;
		d = q;
		d.done = 1'b0;
		if (!enable || restart) begin
			d.cnt = 24'h000000;
			d.cur = 13'h0000;
		end else if (sample_valid) begin
			// a zero period behaves as one sample
			if (24'(q.cnt + 24'h000001) >= period) begin
				d.last = hi;
				d.periods = 8'(q.periods + 8'h01);
				d.done = 1'b1;
				d.cnt = 24'h000000;
				d.cur = 13'h0000;
			end else begin
				d.cnt = 24'(q.cnt + 24'h000001);
				d.cur = hi;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done = q.done;
	assign peak = q.last;
	assign count = q.periods;

endmodule : peak_track

`default_nettype wire

// ==== tb/signal_monitor_fast_detect_regs_tb.sv ====
/*
 * Self-checking bench for the level monitor register bank: serial port
 * read and write tasks, sample feeding and sideband watching.
 * Assumes the design files under hw/ are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module signal_monitor_fast_detect_regs_tb;

	logic clk;
	logic sys_rst;
	logic spi_sclk;
	logic spi_csb_n;
	logic spi_sdio_in;
	logic spi_sdio_out;
	logic spi_sdio_oe;
	logic sample_valid;
	logic signed [13:0] sample;
	logic sync_pulse;
	logic detect_compare;
	logic level_threshold_detect_pin;
	mon_pkg::detect_cfg_t detect_cfg;
	logic [1:0] sync_mode;
	mon_pkg::sideband_t sideband_serial_port;
	int error_cnt = 0;
	int total_checks = 0;
	int sb_cnt = 0;
	logic [12:0] sb_peak;
	logic [7:0] v;
	// address, write value, read-back value
	logic [30:0] wt [7] = '{{15'h247, 8'hff, 8'hff}, {15'h248, 8'hff, 8'h1f},
		{15'h249, 8'ha5, 8'ha5}, {15'h24a, 8'hff, 8'h1f}, {15'h24b, 8'h34, 8'h34},
		{15'h24c, 8'h12, 8'h12}, {15'h26f, 8'h01, 8'h01}};
	// control byte, compare input, expected pin
	logic [9:0] ft [5] = '{{8'h0c, 1'b0, 1'b1}, {8'h08, 1'b1, 1'b0}, {8'h01, 1'b1, 1'b1},
		{8'h01, 1'b0, 1'b0}, {8'h00, 1'b1, 1'b0}};

	signal_monitor_fast_detect_regs u_signal_monitor_fast_detect_regs (
		.clk(clk),
		.sys_rst(sys_rst),
		.spi_sclk(spi_sclk),
		.spi_csb_n(spi_csb_n),
		.spi_sdio_in(spi_sdio_in),
		.spi_sdio_out(spi_sdio_out),
		.spi_sdio_oe(spi_sdio_oe),
		.sample_valid(sample_valid),
		.sample(sample),
		.sync_pulse(sync_pulse),
		.detect_compare(detect_compare),
		.level_threshold_detect_pin(level_threshold_detect_pin),
		.detect_cfg(detect_cfg),
		.sync_mode(sync_mode),
		.sideband_serial_port(sideband_serial_port)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// sideband valid is a single-cycle pulse, so it is counted here
	always @(posedge clk) begin
		if (sideband_serial_port.valid === 1'b1) begin
			sb_cnt <= sb_cnt + 1;
			sb_peak <= sideband_serial_port.peak;
		end
	end

	// ---------------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------------
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// phases of six clocks keep well clear of the four-clock minimum
	task sbit(input logic b, output logic r);
		spi_sdio_in <= b;
		repeat (6) @(posedge clk);
		r = spi_sdio_out;
		spi_sclk <= 1'b1;
		repeat (6) @(posedge clk);
		spi_sclk <= 1'b0;
	endtask : sbit

	task xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] q);
		logic r;
		logic [23:0] f;
		f = {rd, a, wd};
		spi_csb_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 23; i >= 0; i--) begin
			sbit(f[i], r);
			if (i < 8)
				q[i] = r;
		end
		repeat (6) @(posedge clk);
		chk("sdio oe", {63'h0, rd}, spi_sdio_oe);
		spi_csb_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk("sdio oe", 64'h0, spi_sdio_oe);
	endtask : xfer

	task wr(input logic [14:0] a, input logic [7:0] d);
		xfer(1'b0, a, d, v);
	endtask : wr

	// sdio_in alternates while the device drives, never a held level
	task rchk(input logic [14:0] a, input logic [7:0] e);
		xfer(1'b1, a, 8'h55, v);
		chk($sformatf("reg %h", a), e, v);
	endtask : rchk

	task feed(input int n, input logic signed [13:0] s);
		repeat (n) begin
			sample <= s;
			sample_valid <= 1'b1;
			@(posedge clk) sample_valid <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask : feed

	// ---------------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		spi_sclk = 1'b0;
		spi_csb_n = 1'b1;
		spi_sdio_in = 1'b0;
		sample_valid = 1'b0;
		sample = 14'h0000;
		sync_pulse = 1'b0;
		detect_compare = 1'b0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk("detect_cfg", 64'h0, detect_cfg);
		chk("detect pin", 64'h0, level_threshold_detect_pin);
		for (int a = 16'h245; a <= 16'h27a; a++) begin
			if (a < 16'h275 || a > 16'h278)
				rchk(a[14:0], a == 16'h271 ? 8'h80 : a == 16'h274 ? 8'h01 : 8'h00);
		end
		rchk(15'h300, 8'h00);
		for (int i = 0; i < 7; i++) begin
			wr(wt[i][30:16], wt[i][15:8]);
			rchk(wt[i][30:16], wt[i][7:0]);
		end
		chk("detect_cfg", {21'h0, 13'h1fff, 13'h1fa5, 16'h1234, 1'b0}, detect_cfg);
		chk("sync_mode", 64'h1, sync_mode);
		wr(15'h26f, 8'h00);
		for (int i = 0; i < 5; i++) begin
			detect_compare <= ft[i][1];
			wr(15'h245, ft[i][9:2]);
			repeat (3) @(posedge clk);
			chk("detect pin", ft[i][0], level_threshold_detect_pin);
			chk("detect enable", ft[i][2], detect_cfg.enable);
		end
		wr(15'h271, 8'h04);
		wr(15'h279, 8'h01);
		wr(15'h27a, 8'h02);
		feed(4, -14'sd900);
		repeat (20) @(posedge clk);
		chk("sideband count", 64'h0, sb_cnt);
		wr(15'h270, 8'h02);
		feed(3, 14'sd100);
		feed(1, -14'sd1001);
		for (int i = 0; i < 50 && sb_cnt == 0; i++)
			@(posedge clk);
		if (sb_cnt == 0) begin
			error_cnt++;
			$display("unexpected sideband wait expected pulse seen none");
		end
		chk("sideband count", 64'h1, sb_cnt);
		chk("sideband peak", 64'h3e9, sb_peak);
		wr(15'h274, 8'h11);
		rchk(15'h275, 8'h80);
		rchk(15'h276, 8'hf4);
		rchk(15'h277, 8'h01);
		rchk(15'h278, 8'h01);
		rchk(15'h274, 8'h01);
		wr(15'h275, 8'haa);
		rchk(15'h275, 8'h80);
		wr(15'h27a, 8'h00);
		feed(4, 14'sd50);
		repeat (20) @(posedge clk);
		chk("sideband count", 64'h1, sb_cnt);
		// continuous sync stays armed, one-shot disarms after one pulse
		wr(15'h26f, 8'h01);
		sync_pulse <= 1'b1;
		@(posedge clk) sync_pulse <= 1'b0;
		repeat (3) @(posedge clk);
		chk("sync_mode", 64'h1, sync_mode);
		wr(15'h26f, 8'h02);
		chk("sync_mode", 64'h2, sync_mode);
		sync_pulse <= 1'b1;
		@(posedge clk) sync_pulse <= 1'b0;
		repeat (3) @(posedge clk);
		chk("sync_mode", 64'h0, sync_mode);
		print_verdict;
	end

endmodule : signal_monitor_fast_detect_regs_tb

`default_nettype wire
